/* inc/cmp_pkg.sv */
package cmp_pkg;

    // ------------------------------------------------------------
    // sizes and addresses
    // ------------------------------------------------------------
    localparam int          NUM_CMP      = 5;
    localparam int          NO_AMP_IDX   = 3;
    localparam logic [7:0]  STATUS_OFS   = 8'h00;
    localparam logic [7:0]  CTL_BASE     = 8'h10;
    localparam logic [7:0]  CTL_STRIDE   = 8'h20;
    localparam logic [7:0]  IRQ_OFS      = 8'hC0;

    // alias selector, address bits 3:2
    localparam logic [1:0]  OP_WRITE     = 2'h0;
    localparam logic [1:0]  OP_CLR       = 2'h1;
    localparam logic [1:0]  OP_SET       = 2'h2;
    localparam logic [1:0]  OP_INV       = 2'h3;

    // ------------------------------------------------------------
    // status word fields
    // ------------------------------------------------------------
    localparam int          EVT_LSB      = 16;
    localparam int          IDLE_BIT     = 13;
    localparam int          OUT_LSB      = 0;

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int          AMP_ON_BIT   = 31;
    localparam int          GAIN_BIT     = 30;
    localparam int          HYS_EDGE_BIT = 28;
    localparam int          HYS_LSB      = 24;
    localparam int          FSRC_LSB     = 20;
    localparam int          FEN_BIT      = 19;
    localparam int          FDIV_LSB     = 16;
    localparam int          ON_BIT       = 15;
    localparam int          OE_BIT       = 14;
    localparam int          INV_BIT      = 13;
    localparam int          LPWR_BIT     = 12;
    localparam int          EVENT_LATCHED_BIT     = 9;
    localparam int          COMPARE_RESULT_BIT     = 8;
    localparam int          EVENT_POLARITY_LSB    = 6;

    localparam logic [31:0] CTL_WMASK        = 32'hD37F_F0D3;
    localparam logic [31:0] CTL_WMASK_NO_AMP = 32'h137F_E0D3;
    localparam logic [31:0] CTL_RESET        = 32'h0000_0000;
    localparam logic        IDLE_RESET       = 1'b0;

    localparam logic [1:0]  EV_OFF       = 2'h0;
    localparam logic [1:0]  EV_RISE      = 2'h1;
    localparam logic [1:0]  EV_FALL      = 2'h2;
    localparam logic [1:0]  EV_ANY       = 2'h3;

    localparam logic [1:0]  FILT_HITS    = 2'h3;
    localparam int          DIV_W        = 7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       comp_on;
        logic       filt_en;
        logic       invert;
        logic [2:0] div;
        logic [1:0] event_polarity;
    } chan_cfg_s;

    typedef struct packed {
        logic       comp_enable;
        logic       amp_enable;
        logic       unity_gain_select;
        logic       amp_low_power;
        logic       hysteresis_edge_select;
        logic [1:0] hysteresis_level;
    } analog_ctl_s;

endpackage

/* rtl/cmp_channel.sv */
`timescale 1ns/1ns
module cmp_channel (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               run,
    input  wire logic               raw_async,
    input  wire logic               src_tick,
    input  wire cmp_pkg::chan_cfg_s cfg,
    output logic                    result,
    output logic                    event_pulse
);

    typedef struct packed {
        logic                      s1;
        logic                      s2;
        logic [cmp_pkg::DIV_W-1:0] div_cnt;
        logic [1:0]                hits;
        logic                      cand;
        logic                      filt;
        logic                      adj;
        logic                      evt;
    } chan_state_s;

    chan_state_s               st;
    chan_state_s               n;
    logic [cmp_pkg::DIV_W-1:0] div_top;
    logic                      dtick;

    assign div_top = 7'((8'h01 << cfg.div) - 8'h01);
    // >= so a smaller divide never waits for the counter to wrap
    assign dtick   = src_tick && (st.div_cnt >= div_top);

    always_comb begin
        n     = st;
        n.s1  = raw_async;
        n.s2  = st.s1;
        n.evt = 1'b0;
        if (run) begin
            if (src_tick) begin
                n.div_cnt = dtick ? '0 : st.div_cnt + 7'h01;
            end
            if (!cfg.filt_en) begin
                n.filt = st.s2;
                n.cand = st.s2;
                n.hits = '0;
            end else if (dtick) begin
                if (st.s2 != st.cand) begin
                    n.cand = st.s2;
                    n.hits = 2'h1;
                end else if (st.hits != cmp_pkg::FILT_HITS) begin
                    n.hits = st.hits + 2'h1;
                end
                if (st.s2 == st.cand && st.hits == cmp_pkg::FILT_HITS - 2'h1) begin
                    n.filt = st.cand;
                end
            end
            n.adj = cfg.comp_on & (n.filt ^ cfg.invert);
            unique case (cfg.event_polarity)
                cmp_pkg::EV_ANY:  n.evt = n.adj != st.adj;
                cmp_pkg::EV_FALL: n.evt = st.adj & ~n.adj;
                cmp_pkg::EV_RISE: n.evt = ~st.adj & n.adj;
                cmp_pkg::EV_OFF:  n.evt = 1'b0;
            endcase
        end
    end

    // raw input is asynchronous, so s1 feeds only s2
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= n;
        end
    end

    assign result      = st.adj;
    assign event_pulse = st.evt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    filt_three_a: assert property (ce && run && cfg.filt_en && n.filt != st.filt
        |-> dtick && st.hits == 2'h2 && st.s2 == st.cand)
        else $error("filter output moved before three stable samples");

    event_polarity_off_a: assert property (ce && cfg.event_polarity == cmp_pkg::EV_OFF |=> !event_pulse)
        else $error("event raised with event generation off");

    pol_bypass_a: assert property (ce && run && cfg.comp_on && !cfg.filt_en
        |=> result == ($past(st.s2) ^ $past(cfg.invert)))
        else $error("output polarity not applied");

endmodule

/* rtl/comparator_control_status_regs.sv */
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
// What this block does
// - five hardware-set event flags sit at status bits 16 to 20
// - a set event flag blocks further events, triggers and interrupts
// - control bit 9 is the event bit; writing zero re-arms detection
// - status bits 4 to 0 mirror the polarity-adjusted outputs, reset zero
// - status bit 13 halts all comparators and op amps in idle
// - control bit 13 inverts the raw result before output and events
// - control bit 8 reads the polarity-adjusted output, read-only
// - control bit 15 enables the comparator
// - control bit 14 drives the result onto the output pin while control bit 15 is set
// - bits 22 to 20 select the filter clock source
// - bits 18 to 16 divide the filter clock by two to that power
// - control bit 19 enables the digital filter, else bypass
// - bits 25 to 24 select the hysteresis level to the analog cell
// - control bit 28 picks which edge gets hysteresis
// - control bit 31 enables the op amp and its pin
// - control bit 30 selects unity gain, else open loop
// - control bit 12 selects op amp low-power mode
// - the fourth channel has no op amp bits
// - interrupt flag sets on any enabled event and stays until cleared
// - unimplemented bits read as zero
// - event polarity field: any, falling, rising or off
// - clear, set and invert aliases at offsets 4, 8 and C
module comparator_control_status_regs (
    input  wire logic                                      clk,
    input  wire logic                                      rst,
    input  wire logic                                      ce,
    input  wire logic                                      psel,
    input  wire logic                                      penable,
    input  wire logic                                      pwrite,
    input  wire logic [7:0]                                paddr,
    input  wire logic [31:0]                               pwdata,
    input  wire logic [3:0]                                pstrb,
    output logic [31:0]                                    prdata,
    output logic                                           pready,
    output logic                                           pslverr,
    input  wire logic                                      idle_mode,
    input  wire logic [cmp_pkg::NUM_CMP-1:0]               raw_result,
    input  wire logic                                      peripheral_bus_clock_two_tick,
    input  wire logic                                      pwm_special_event,
    input  wire logic                                      reference_clock_three_tick,
    input  wire logic [3:0]                                timer_match,
    output cmp_pkg::analog_ctl_s [cmp_pkg::NUM_CMP-1:0]    analog_ctl,
    output logic [cmp_pkg::NUM_CMP-1:0]                    out_pin,
    output logic [cmp_pkg::NUM_CMP-1:0]                    out_pin_oe,
    output logic [cmp_pkg::NUM_CMP-1:0]                    event_trigger,
    output logic [cmp_pkg::NUM_CMP-1:0]                    interrupt_flag
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                                   stop_in_idle;
        logic [cmp_pkg::NUM_CMP-1:0][31:0]      ctl;
        logic [cmp_pkg::NUM_CMP-1:0]            irq;
        logic [31:0]                            rdata;
        logic                                   err;
        logic                                   ack;
    } regs_state_s;

    localparam regs_state_s RST_STATE = '{
        stop_in_idle: cmp_pkg::IDLE_RESET,
        ctl:          {cmp_pkg::NUM_CMP{cmp_pkg::CTL_RESET}},
        irq:          '0,
        rdata:        '0,
        err:          1'b0,
        ack:          1'b0
    };

    regs_state_s                   r;
    regs_state_s                   n;

    logic [cmp_pkg::NUM_CMP-1:0]   ctl_hit;
    logic [cmp_pkg::NUM_CMP-1:0]   result;
    logic [cmp_pkg::NUM_CMP-1:0]   chan_evt;
    logic [cmp_pkg::NUM_CMP-1:0]   trig;
    logic                          aligned;
    logic                          st_hit;
    logic                          irq_hit;
    logic                          mapped;
    logic                          commit;
    logic                          wr;
    logic                          halt;
    logic [1:0]                    op;
    logic [31:0]                   be;
    logic [31:0]                   st_word;
    logic [31:0]                   irq_word;
    logic [7:0]                    src_vec;

    // ------------------------------------------------------------
    // alias write helper
    // ------------------------------------------------------------
    function automatic logic [31:0] apply_op(
        input logic [1:0]  code,
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [31:0] lanes
    );
        logic [31:0] v;
        v = wd & lanes;
        unique case (code)
            cmp_pkg::OP_WRITE: apply_op = (old & ~lanes) | v;
            cmp_pkg::OP_CLR:   apply_op = old & ~v;
            cmp_pkg::OP_SET:   apply_op = old | v;
            cmp_pkg::OP_INV:   apply_op = old ^ v;
        endcase
    endfunction

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign aligned = paddr[1:0] == 2'h0;
    assign op      = paddr[3:2];
    assign st_hit  = aligned && paddr[7:4] == cmp_pkg::STATUS_OFS[7:4];
    assign irq_hit = aligned && paddr[7:4] == cmp_pkg::IRQ_OFS[7:4];
    assign mapped  = st_hit || irq_hit || (|ctl_hit);
    assign be      = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // one wait state: read data is captured, then the access ends
    assign pready  = r.ack && ce;
    assign commit  = psel && penable && pready;
    assign wr      = commit && pwrite && mapped;
    assign prdata  = r.rdata;
    assign pslverr = pready && r.err;

    assign halt    = r.stop_in_idle && idle_mode;

    // filter clock sources, system clock ticks every cycle
    assign src_vec = {timer_match, reference_clock_three_tick, pwm_special_event, peripheral_bus_clock_two_tick, 1'b1};

    // ------------------------------------------------------------
    // read views
    // ------------------------------------------------------------
    always_comb begin
        st_word = '0;
        st_word[cmp_pkg::IDLE_BIT] = r.stop_in_idle;
        st_word[cmp_pkg::OUT_LSB +: cmp_pkg::NUM_CMP] = result;
        for (int i = 0; i < cmp_pkg::NUM_CMP; i++) begin
            st_word[cmp_pkg::EVT_LSB + i] = r.ctl[i][cmp_pkg::EVENT_LATCHED_BIT];
        end
        irq_word = '0;
        irq_word[cmp_pkg::NUM_CMP-1:0] = r.irq;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] rd;
        logic [31:0] ws;
        logic [31:0] wc;
        logic [31:0] wi;
        logic [31:0] cv;
        logic [31:0] m;
        logic        clr;
        rd = '0;
        ws = apply_op(op, st_word, pwdata, be);
        wi = apply_op(op, irq_word, pwdata, be);
        wc = '0;
        cv = '0;
        m  = '0;
        clr = 1'b0;
        n  = r;

        if (st_hit) begin
            rd = st_word;
        end else if (irq_hit) begin
            rd = irq_word;
        end
        for (int i = 0; i < cmp_pkg::NUM_CMP; i++) begin
            if (ctl_hit[i]) begin
                rd = r.ctl[i];
                rd[cmp_pkg::COMPARE_RESULT_BIT] = result[i];
            end
        end

        if (psel && penable && !r.ack) begin
            n.ack   = 1'b1;
            n.rdata = mapped ? rd : '0;
            n.err   = !mapped;
        end
        if (commit) begin
            n.ack = 1'b0;
        end

        if (wr && st_hit) begin
            n.stop_in_idle = ws[cmp_pkg::IDLE_BIT];
        end

        for (int i = 0; i < cmp_pkg::NUM_CMP; i++) begin
            cv = r.ctl[i];
            cv[cmp_pkg::COMPARE_RESULT_BIT] = result[i];
            wc = apply_op(op, cv, pwdata, be);
            // no op amp on this channel, its amp bits stay zero
            m  = (i == cmp_pkg::NO_AMP_IDX) ? cmp_pkg::CTL_WMASK_NO_AMP : cmp_pkg::CTL_WMASK;
            if (wr && ctl_hit[i]) begin
                n.ctl[i] = (wc & m) | (r.ctl[i] & ~m);
            end
            // either view clears, a new event in the same cycle wins
            clr = wr && ((ctl_hit[i] && !wc[cmp_pkg::EVENT_LATCHED_BIT]) ||
                         (st_hit && !ws[cmp_pkg::EVT_LSB + i]));
            n.ctl[i][cmp_pkg::EVENT_LATCHED_BIT] = (r.ctl[i][cmp_pkg::EVENT_LATCHED_BIT] && !clr) || trig[i];
            clr = wr && irq_hit && !wi[i];
            n.irq[i] = (r.irq[i] && !clr) || trig[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= RST_STATE;
        end else if (ce) begin
            r <= n;
        end
    end

    assign event_trigger  = trig & {cmp_pkg::NUM_CMP{ce}};
    assign interrupt_flag = r.irq;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < cmp_pkg::NUM_CMP; gi++) begin : g_ch
            localparam logic [7:0] ADR = 8'(cmp_pkg::CTL_BASE + cmp_pkg::CTL_STRIDE * gi);
            cmp_pkg::chan_cfg_s cfg;

            assign ctl_hit[gi] = aligned && paddr[7:4] == ADR[7:4];

            assign cfg.comp_on = r.ctl[gi][cmp_pkg::ON_BIT];
            assign cfg.filt_en = r.ctl[gi][cmp_pkg::FEN_BIT];
            assign cfg.invert  = r.ctl[gi][cmp_pkg::INV_BIT];
            assign cfg.div     = r.ctl[gi][cmp_pkg::FDIV_LSB +: 3];
            assign cfg.event_polarity   = r.ctl[gi][cmp_pkg::EVENT_POLARITY_LSB +: 2];

            cmp_channel u_ch (
                .clk         (clk),
                .rst         (rst),
                .ce          (ce),
                .run         (!halt),
                .raw_async   (raw_result[gi]),
                .src_tick    (src_vec[r.ctl[gi][cmp_pkg::FSRC_LSB +: 3]]),
                .cfg         (cfg),
                .result      (result[gi]),
                .event_pulse (chan_evt[gi])
            );

            // a latched event masks the next one until software re-arms
            assign trig[gi] = chan_evt[gi] && !r.ctl[gi][cmp_pkg::EVENT_LATCHED_BIT]
                           && cfg.comp_on && !halt;

            assign analog_ctl[gi].comp_enable            = cfg.comp_on && !halt;
            assign analog_ctl[gi].amp_enable             = r.ctl[gi][cmp_pkg::AMP_ON_BIT] && !halt;
            assign analog_ctl[gi].unity_gain_select      = r.ctl[gi][cmp_pkg::GAIN_BIT];
            assign analog_ctl[gi].amp_low_power          = r.ctl[gi][cmp_pkg::LPWR_BIT];
            assign analog_ctl[gi].hysteresis_edge_select = r.ctl[gi][cmp_pkg::HYS_EDGE_BIT];
            assign analog_ctl[gi].hysteresis_level       = r.ctl[gi][cmp_pkg::HYS_LSB +: 2];

            assign out_pin[gi]    = result[gi];
            assign out_pin_oe[gi] = r.ctl[gi][cmp_pkg::OE_BIT] && cfg.comp_on;
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence apb_setup;
        psel && !penable;
    endsequence

    sequence apb_access;
        psel && penable;
    endsequence

    property apb_answer_p;
        @(posedge clk) disable iff (rst || !ce)
        apb_setup ##1 apb_access |-> ##[0:1] pready;
    endproperty

    apb_answer_a: assert property (apb_answer_p)
        else $error("bus access not answered in time");

    property set_alias_p;
        wr && ctl_hit[0] && op == cmp_pkg::OP_SET && pstrb == 4'hF
        |=> (r.ctl[0] & $past(pwdata) & cmp_pkg::CTL_WMASK) == ($past(pwdata) & cmp_pkg::CTL_WMASK);
    endproperty

    set_alias_a: assert property (set_alias_p)
        else $error("set alias did not set control bits");

    unimpl_zero_a: assert property (apb_setup ##1 apb_access
        ##1 (apb_access and (pready && st_hit && !pwrite))
        |-> prdata[31:21] == '0 && prdata[15:14] == '0 && prdata[12:5] == '0)
        else $error("unimplemented status bits read nonzero");

    idle_halt_a: assert property (r.stop_in_idle && idle_mode |-> analog_ctl[0].comp_enable == 1'b0
        && analog_ctl[4].amp_enable == 1'b0 && event_trigger == '0)
        else $error("channels still running in idle");

    amp_four_a: assert property (r.ctl[cmp_pkg::NO_AMP_IDX][cmp_pkg::AMP_ON_BIT] == 1'b0
        && r.ctl[cmp_pkg::NO_AMP_IDX][cmp_pkg::GAIN_BIT] == 1'b0
        && r.ctl[cmp_pkg::NO_AMP_IDX][cmp_pkg::LPWR_BIT] == 1'b0)
        else $error("op amp bits present on channel without op amp");

    generate
        for (gi = 0; gi < cmp_pkg::NUM_CMP; gi++) begin : g_chk
            evt_block_a: assert property (r.ctl[gi][cmp_pkg::EVENT_LATCHED_BIT] |-> !event_trigger[gi])
                else $error("trigger while event latched");

            evt_set_a: assert property (ce && trig[gi] ##1 !(wr && (st_hit || ctl_hit[gi])) [*2]
                |-> st_word[cmp_pkg::EVT_LSB + gi])
                else $error("event flag not latched");

            evt_clear_a: assert property (wr && ctl_hit[gi] && op == cmp_pkg::OP_WRITE && pstrb[1]
                && !pwdata[cmp_pkg::EVENT_LATCHED_BIT] && !trig[gi] |=> !r.ctl[gi][cmp_pkg::EVENT_LATCHED_BIT])
                else $error("event bit not cleared by write of zero");

            irq_sticky_a: assert property (ce && trig[gi] |=> interrupt_flag[gi]
                ##1 (interrupt_flag[gi] || $past(wr && irq_hit)))
                else $error("interrupt flag not set or not held");

            pin_gate_a: assert property (!r.ctl[gi][cmp_pkg::OE_BIT] |-> !out_pin_oe[gi])
                else $error("pin driven with output disabled");
        end
    endgenerate

endmodule

/* tb/analog_cells.sv */
`timescale 1ns/1ns
module analog_cells (
    input  wire logic                                   clk,
    input  wire cmp_pkg::analog_ctl_s [cmp_pkg::NUM_CMP-1:0] analog_ctl,
    input  wire logic [cmp_pkg::NUM_CMP-1:0]            level,
    output logic [cmp_pkg::NUM_CMP-1:0]                 raw_result
);
    initial raw_result = '0;
    // a disabled cell toggles so a stale level never looks valid
    always @(posedge clk)
        for (int i = 0; i < cmp_pkg::NUM_CMP; i++)
            raw_result[i] <= analog_ctl[i].comp_enable ? level[i] : ~raw_result[i];
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, idle_mode, er;
    logic [7:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd, d, e;
    logic [6:0] tick;
    logic [4:0] level, raw, pin, oe, trig, irq;
    cmp_pkg::analog_ctl_s [4:0] actl;
    int failures = 0, cmp_count = 0, ntrig = 0;
    comparator_control_status_regs u_comparator_control_status_regs (.clk(clk), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .raw_result(raw),
        .peripheral_bus_clock_two_tick(tick[0]), .pwm_special_event(tick[1]), .reference_clock_three_tick(tick[2]),
        .timer_match(tick[6:3]), .analog_ctl(actl), .out_pin(pin), .out_pin_oe(oe),
        .event_trigger(trig), .interrupt_flag(irq));
    analog_cells u_analog_cells (.clk(clk), .analog_ctl(actl), .level(level), .raw_result(raw));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        tick <= 7'($urandom);
        if (trig[0] === 1'b1) ntrig <= ntrig + 1;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle cycle, so a following call never re-raises psel in the same step
        @(posedge clk);
    endtask
    task automatic close_out;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        close_out();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h61da));
        rst = 1'b1; ce = 1'b1; pstrb = 4'hF; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        idle_mode = 1'b0; level = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, 8'h00, 0); chk(rd, 0);
        for (int i = 0; i < 5; i++) begin
            d = $urandom & 32'hFFFF_7F3F; // comparator off, no events
            e = d & (i == cmp_pkg::NO_AMP_IDX ? cmp_pkg::CTL_WMASK_NO_AMP : cmp_pkg::CTL_WMASK);
            apb(1, 8'(8'h10 + i * 32), d);
            apb(0, 8'(8'h10 + i * 32), 0); chk(rd, e);
            chk(32'(actl[i]), 32'({1'b0, e[31], e[30], e[12], e[28], e[25:24]}));
        end
        apb(0, 8'hE0, 0); chk(32'(er), 1);
        // switch on with events off, so settling of the cells raises nothing
        apb(1, 8'h10, 32'h0000_8000);
        apb(1, 8'h30, 32'h0009_8000);
        apb(1, 8'h50, 32'h0000_A000);
        repeat (20) @(posedge clk);
        apb(1, 8'h18, 32'h0000_0040);
        apb(1, 8'h38, 32'h0000_00C0);
        apb(1, 8'h58, 32'h0000_0080);
        level <= 5'h01;
        repeat (8) @(posedge clk);
        apb(0, 8'h00, 0); chk(rd, 32'h0001_0005);
        chk(32'(irq), 1);
        level <= 5'h00;
        repeat (8) @(posedge clk);
        level <= 5'h01;
        repeat (8) @(posedge clk);
        chk(ntrig, 1);
        apb(1, 8'h14, 32'h0000_0200);
        apb(0, 8'h00, 0); chk(rd, 32'h0000_0005);
        // one-cycle glitch must not pass the filter
        level <= 5'h03;
        @(posedge clk);
        level <= 5'h01;
        repeat (10) @(posedge clk);
        chk(32'({pin[1], irq[1]}), 0);
        level <= 5'h03;
        repeat (16) @(posedge clk);
        chk(32'({pin[1], irq[1]}), 3);
        level <= 5'h07;
        repeat (8) @(posedge clk);
        apb(0, 8'h00, 0); chk(rd, 32'h0006_0003);
        apb(1, 8'h18, 32'h0000_6000);
        repeat (8) @(posedge clk);
        apb(0, 8'h10, 0); chk(rd, 32'h0000_E040);
        chk(32'({pin[0], oe[0]}), 1);
        apb(1, 8'hC0, 0); chk(32'(irq), 0);
        // everything frozen while the clock enable is low
        ce <= 1'b0;
        level <= 5'h06;
        repeat (6) @(posedge clk);
        chk(32'(pin[0]), 0);
        ce <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'({pin[0], irq[0]}), 3);
        apb(1, 8'h90, 32'h4000_1000);
        apb(1, 8'h98, 32'h8000_0000);
        chk(32'(actl[4]), 32'h0000_0038);
        // lane one only, so the event flags survive
        pstrb <= 4'h2;
        apb(1, 8'h00, 32'h0000_2000);
        pstrb <= 4'hF;
        idle_mode <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'({actl[0].comp_enable, actl[4].amp_enable}), 0);
        apb(0, 8'h00, 0); chk(rd, 32'h0007_2003);
        close_out();
    end
endmodule
